// File: hdl/acc_top.sv
// Converter control: channel decode, clocking, triggering, sequencing and result
`timescale 1ns/1ps
`default_nettype none
module acc_top #(
    parameter int TICK_CYC = acc_pkg::TICK_1K_CYC
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic ctrl_write,
    input wire acc_pkg::acc_ctrl_s ctrl_wdata,
    input wire acc_pkg::acc_cfg_s cfg,
    input wire logic [9:0] compare_value,
    input wire logic [7:0] pin_enable_register_1,
    input wire logic result_low_read,
    input wire logic stop3_mode,
    input wire logic clock_module_reference_out,
    input wire logic periodic_use_reference,
    input wire logic [acc_pkg::RATE_W-1:0] periodic_rate_select,
    input wire logic comparator_high,
    output acc_pkg::acc_route_s route,
    output logic conversion_done_flag,
    output logic conversion_irq,
    output logic conversion_active,
    output logic [9:0] result,
    output logic hardware_conversion_trigger
);
    // Latched control word
    acc_pkg::acc_ctrl_s ctrl;
    // Sequencer state
    acc_pkg::acc_state_e state;
    acc_pkg::acc_state_e next_state;
    // Conversion clock divider and enable
    logic half;
    logic [1:0] local_div;
    // Sample counter and approximation registers
    logic [4:0] sample_cnt;
    logic [9:0] sar;
    logic [9:0] bit_mask;
    logic ovf_q;
    // Periodic counter overflow pulse
    wire ovf;

    // Periodic counter, kept running in every power mode
    acc_periodic #(
        .TICK_CYC(TICK_CYC)
    ) u_periodic (
        .mclk(mclk),
        .rst(rst),
        .clock_module_reference_out(clock_module_reference_out),
        .use_reference(periodic_use_reference),
        .periodic_rate_select(periodic_rate_select),
        .overflow(ovf)
    );

    // Channel decode helper, used for both routing and start checks
    function automatic logic is_off(input logic [4:0] ch);
        is_off = (ch == acc_pkg::CH_OFF);
    endfunction

    // Conversion clock tick selection; external alternate clock not offered
    wire conv_tick = (cfg.clk_sel == acc_pkg::CLK_BUS) ? 1'b1 :
                     (cfg.clk_sel == acc_pkg::CLK_BUS_DIV2) ? half :
                     (cfg.clk_sel == acc_pkg::CLK_LOCAL) ? (local_div == 2'b11) :
                     1'b1;
    // Single-cycle trigger, one per overflow
    wire hw_start = cfg.hw_trig_enable && hardware_conversion_trigger;
    wire sw_start = ctrl_write && !cfg.hw_trig_enable && !is_off(ctrl_wdata.input_channel_select);
    wire chan_off = is_off(ctrl.input_channel_select);
    wire start = !ctrl_write && hw_start && !chan_off;
    wire [4:0] sample_len = cfg.long_sample ? acc_pkg::SAMPLE_LONG : acc_pkg::SAMPLE_SHORT;
    // Bit trial: keep the bit when the comparator says input is higher
    wire [9:0] trial = sar | bit_mask;
    wire [9:0] next_sar = comparator_high ? trial : sar;
    wire last_bit = bit_mask[0];
    wire done = (state == acc_pkg::ST_CONVERT) && conv_tick && last_bit;
    // 8-bit mode drops the two low bits, right justified
    wire [9:0] formatted = cfg.mode8 ? (next_sar >> acc_pkg::RES8_SHIFT) : next_sar;
    wire cmp_true = cfg.cmp_greater_equal ? (formatted >= compare_value) :
                    (formatted < compare_value);
    wire set_done = done && (!cfg.cmp_enable || cmp_true);
    wire clr_done = ctrl_write || result_low_read;

    // Next-state logic
    always_comb
    begin
        next_state = state;
        unique case (state)
            acc_pkg::ST_IDLE:
                if (sw_start || start)
                    next_state = acc_pkg::ST_SAMPLE;
            acc_pkg::ST_SAMPLE:
                if (ctrl_write)
                    next_state = sw_start ? acc_pkg::ST_SAMPLE : acc_pkg::ST_IDLE;
                else if (conv_tick && sample_cnt == 5'h00)
                    next_state = acc_pkg::ST_CONVERT;
            acc_pkg::ST_CONVERT:
                if (ctrl_write)
                    next_state = sw_start ? acc_pkg::ST_SAMPLE : acc_pkg::ST_IDLE;
                else if (done)
                    next_state = (ctrl.continuous && !chan_off) ?
                                 acc_pkg::ST_SAMPLE : acc_pkg::ST_IDLE;
            default:
                next_state = acc_pkg::ST_IDLE;
        endcase
    end

    // Result register written on each finished conversion
    acc_result_reg #(
        .W(acc_pkg::RES_W)
    ) u_result (
        .mclk(mclk),
        .rst(rst),
        .wr(done),
        .wdata(formatted),
        .rdata(result)
    );

    // Control word, dividers and trigger pulse
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            ctrl <= '{int_enable: 1'b0, continuous: 1'b0,
                      input_channel_select: acc_pkg::CH_OFF};
            half <= 1'b0;
            local_div <= 2'b00;
            ovf_q <= 1'b0;
            hardware_conversion_trigger <= 1'b0;
        end
        else
        begin
            if (ctrl_write)
                ctrl <= ctrl_wdata;
            half <= ~half;
            local_div <= local_div + 2'b01;
            ovf_q <= ovf;
            hardware_conversion_trigger <= ovf && !ovf_q;
        end
    end

    // Sequencer, sample timer and approximation
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            state <= acc_pkg::ST_IDLE;
            sample_cnt <= '0;
            sar <= acc_pkg::RES_ZERO;
            bit_mask <= acc_pkg::RES_MSB;
            conversion_active <= 1'b0;
        end
        else
        begin
            state <= next_state;
            conversion_active <= (next_state != acc_pkg::ST_IDLE);
            if (next_state == acc_pkg::ST_SAMPLE && state != acc_pkg::ST_SAMPLE)
                sample_cnt <= sample_len;
            else if (next_state == acc_pkg::ST_SAMPLE && state == acc_pkg::ST_SAMPLE && ctrl_write)
                sample_cnt <= sample_len;
            else if (state == acc_pkg::ST_SAMPLE && conv_tick && sample_cnt != 5'h00)
                sample_cnt <= sample_cnt - 5'h01;
            if (state != acc_pkg::ST_CONVERT || next_state != acc_pkg::ST_CONVERT)
            begin
                sar <= acc_pkg::RES_ZERO;
                bit_mask <= acc_pkg::RES_MSB;
            end
            else if (conv_tick)
            begin
                sar <= next_sar;
                bit_mask <= bit_mask >> 1;
            end
        end
    end

    // Done flag and interrupt; a completion in the clear cycle wins
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            conversion_done_flag <= 1'b0;
            conversion_irq <= 1'b0;
        end
        else
        begin
            if (set_done)
                conversion_done_flag <= 1'b1;
            else if (clr_done)
                conversion_done_flag <= 1'b0;
            conversion_irq <= (set_done || (conversion_done_flag && !clr_done)) &&
                              (ctrl_write ? ctrl_wdata.int_enable : ctrl.int_enable);
        end
    end

    // Analog routing from the latched channel; idle low power powers down
    wire [4:0] ch = ctrl.input_channel_select;
    wire ch_pin = (ch <= acc_pkg::CH_PIN_LAST);
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            route <= '0;
        else
        begin
            route.pin_route <= ch_pin ?
                (pin_enable_register_1 & (8'h01 << ch[2:0])) : 8'h00;
            route.ground <= (ch >= acc_pkg::CH_GND_FIRST) && (ch <= acc_pkg::CH_GND_LAST);
            route.reserved <= ((ch >= acc_pkg::CH_RSV_FIRST) && (ch <= acc_pkg::CH_RSV_LAST)) ||
                              (ch == acc_pkg::CH_RSV_HI);
            route.temp_sensor <= (ch == acc_pkg::CH_TEMP);
            route.bandgap <= (ch == acc_pkg::CH_BANDGAP);
            route.ref_high <= (ch == acc_pkg::CH_REFH);
            route.ref_low <= (ch == acc_pkg::CH_REFL);
            route.powered <= !is_off(ch) &&
                             (next_state != acc_pkg::ST_IDLE || !cfg.low_power);
        end
    end

    // Checks beside the logic
    sequence s_write_off;
        ctrl_write && is_off(ctrl_wdata.input_channel_select);
    endsequence
    a_off_goes_idle: assert property (@(posedge mclk) disable iff (rst)
        s_write_off |=> (state == acc_pkg::ST_IDLE) && !conversion_active)
        else $error("disable code did not idle");
    // Front end powers down once the off code reaches the routing
    a_off_unpowered: assert property (@(posedge mclk) disable iff (rst)
        s_write_off |=> ##1 !route.powered)
        else $error("disable code left the front end powered");
    // A trigger pulse never stretches into a second conversion start
    a_trig_one_cycle: assert property (@(posedge mclk) disable iff (rst)
        hardware_conversion_trigger |=> !hardware_conversion_trigger)
        else $error("trigger longer than one cycle");
    // Overflow keeps triggering while the part sits in stop3
    a_stop3_trigger: assert property (@(posedge mclk) disable iff (rst)
        stop3_mode && ovf && !ovf_q |=> hardware_conversion_trigger)
        else $error("trigger lost in stop3");
    a_write_restart: assert property (@(posedge mclk) disable iff (rst)
        sw_start |=> state == acc_pkg::ST_SAMPLE)
        else $error("write did not restart");
    a_done_clears: assert property (@(posedge mclk) disable iff (rst)
        clr_done && !set_done |=> !conversion_done_flag)
        else $error("done flag not cleared");
    a_done_sets: assert property (@(posedge mclk) disable iff (rst)
        set_done |=> conversion_done_flag)
        else $error("done flag not set");
    // Interrupt request only stands while the done flag does
    a_irq_flag: assert property (@(posedge mclk) disable iff (rst)
        conversion_irq |-> conversion_done_flag)
        else $error("interrupt without done flag");
    a_hw_starts: assert property (@(posedge mclk) disable iff (rst)
        start && state == acc_pkg::ST_IDLE |=> state == acc_pkg::ST_SAMPLE)
        else $error("trigger did not start");
    a_single_idle: assert property (@(posedge mclk) disable iff (rst)
        done && !ctrl_write && !ctrl.continuous |=> state == acc_pkg::ST_IDLE)
        else $error("single conversion did not idle");
    // Short results keep the two top bits clear
    a_mode8_range: assert property (@(posedge mclk) disable iff (rst)
        done && cfg.mode8 |=> result[9:8] == 2'b00)
        else $error("short result not right justified");
    a_temp_route: assert property (@(posedge mclk) disable iff (rst)
        ctrl.input_channel_select == acc_pkg::CH_TEMP |=> route.temp_sensor)
        else $error("temperature not routed");
    // Non-pin codes leave every pin switch open
    a_pin_blocked: assert property (@(posedge mclk) disable iff (rst)
        !ch_pin |=> route.pin_route == 8'h00)
        else $error("pin routed for a non-pin code");
    // Ground codes tie the converter input low
    a_ground_route: assert property (@(posedge mclk) disable iff (rst)
        (ch >= acc_pkg::CH_GND_FIRST) && (ch <= acc_pkg::CH_GND_LAST) |=> route.ground)
        else $error("ground not routed");
    // Upper reserved code is flagged as undefined
    a_reserved_route: assert property (@(posedge mclk) disable iff (rst)
        ch == acc_pkg::CH_RSV_HI |=> route.reserved)
        else $error("reserved code not flagged");
    // High reference selects one reference only
    a_ref_route: assert property (@(posedge mclk) disable iff (rst)
        ch == acc_pkg::CH_REFH |=> route.ref_high && !route.ref_low)
        else $error("high reference not routed");
    // A failed compare never raises the flag; a read may still clear it
    a_cmp_gate: assert property (@(posedge mclk) disable iff (rst)
        done && cfg.cmp_enable && !cmp_true && !ctrl_write |=> !$rose(conversion_done_flag))
        else $error("compare gate failed");
endmodule
`default_nettype wire

// File: hdl/acc_pkg.sv
// Package of constants and types for the converter channel and trigger control
package acc_pkg;
    // Channel code width and decode points
    localparam int CH_W = 5;
    localparam logic [4:0] CH_PIN_LAST = 5'h07;
    localparam logic [4:0] CH_GND_FIRST = 5'h08;
    localparam logic [4:0] CH_GND_LAST = 5'h15;
    localparam logic [4:0] CH_RSV_FIRST = 5'h16;
    localparam logic [4:0] CH_RSV_LAST = 5'h19;
    localparam logic [4:0] CH_TEMP = 5'h1a;
    localparam logic [4:0] CH_BANDGAP = 5'h1b;
    localparam logic [4:0] CH_RSV_HI = 5'h1c;
    localparam logic [4:0] CH_REFH = 5'h1d;
    localparam logic [4:0] CH_REFL = 5'h1e;
    localparam logic [4:0] CH_OFF = 5'h1f;
    // Result widths
    localparam int RES_W = 10;
    localparam int RES8_SHIFT = 2;
    localparam logic [9:0] RES_ZERO = 10'h000;
    localparam logic [9:0] RES_MSB = 10'h200;
    // Sample time counts in conversion clock ticks
    localparam logic [4:0] SAMPLE_SHORT = 5'h03;
    localparam logic [4:0] SAMPLE_LONG = 5'h17;
    // Periodic counter widths and the internal 1 kHz tick
    localparam int PER_W = 16;
    localparam int RATE_W = 3;
    localparam real TICK_1K_NS = 1000000.0;
    localparam real MCLK_NS = 8.0;
    localparam int TICK_1K_CYC = int'(TICK_1K_NS / MCLK_NS);
    localparam logic [PER_W-1:0] PER_ONE = 16'h0001;
    localparam logic [PER_W-1:0] PER_BASE = 16'h0008;

    // Conversion clock sources
    typedef enum logic [1:0] {
        CLK_BUS = 2'b00,
        CLK_BUS_DIV2 = 2'b01,
        CLK_LOCAL = 2'b11
    } acc_clk_e;

    // Conversion control state
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SAMPLE = 2'b01,
        ST_CONVERT = 2'b10
    } acc_state_e;

    // Software control word written as one unit
    typedef struct packed {
        logic int_enable;
        logic continuous;
        logic [4:0] input_channel_select;
    } acc_ctrl_s;

    // Configuration word
    typedef struct packed {
        logic long_sample;
        logic low_power;
        logic mode8;
        logic [1:0] clk_sel;
        logic hw_trig_enable;
        logic cmp_enable;
        logic cmp_greater_equal;
    } acc_cfg_s;

    // Analog routing to the front end
    typedef struct packed {
        logic [7:0] pin_route;
        logic ground;
        logic temp_sensor;
        logic bandgap;
        logic ref_high;
        logic ref_low;
        logic reserved;
        logic powered;
    } acc_route_s;
endpackage

// File: hdl/acc_periodic.sv
// Periodic wakeup counter whose overflow feeds the hardware trigger
`timescale 1ns/1ps
`default_nettype none
module acc_periodic #(
    parameter int TICK_CYC = acc_pkg::TICK_1K_CYC
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic clock_module_reference_out,
    input wire logic use_reference,
    input wire logic [acc_pkg::RATE_W-1:0] periodic_rate_select,
    output logic overflow
);
    // Internal 1 kHz divider
    logic [31:0] div;
    // Reference input register stage and previous value
    logic ref_q;
    logic ref_prev;
    // Free running count
    logic [acc_pkg::PER_W-1:0] count;
    // Period limit from the rate bits
    wire [acc_pkg::PER_W-1:0] limit = acc_pkg::PER_BASE << periodic_rate_select;
    wire tick_1k = (div == 32'(TICK_CYC - 1));
    wire tick_ref = ref_q & ~ref_prev;
    wire tick = use_reference ? tick_ref : tick_1k;
    wire wrap = tick && (count >= limit - acc_pkg::PER_ONE);

    // Tick sources and the counter itself
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            div <= '0;
            ref_q <= 1'b0;
            ref_prev <= 1'b0;
            count <= '0;
            overflow <= 1'b0;
        end
        else
        begin
            div <= tick_1k ? '0 : div + 32'h1;
            ref_q <= clock_module_reference_out;
            ref_prev <= ref_q;
            if (tick)
                count <= wrap ? '0 : count + acc_pkg::PER_ONE;
            overflow <= wrap;
        end
    end
endmodule
`default_nettype wire

// File: hdl/acc_result_reg.sv
// Result holding register with its read data taken from a flop
`timescale 1ns/1ps
`default_nettype none
module acc_result_reg #(
    parameter int W = acc_pkg::RES_W
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic wr,
    input wire logic [W-1:0] wdata,
    output logic [W-1:0] rdata
);
    // Stored word
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            rdata <= '0;
        else if (wr)
            rdata <= wdata;
    end
endmodule
`default_nettype wire

// File: testbench/acc_analog_model.sv
// Analog front end model answering the converter's trial comparisons
`timescale 1ns/1ps
`default_nettype none
module acc_analog_model (
    input wire logic mclk,
    input wire logic [7:0] pin_level,
    input wire logic bandgap_buffer_enable,
    input wire acc_pkg::acc_route_s route,
    output logic comparator_high
);
    // Reserved inputs settle nowhere, so they flip every cycle
    logic flip = 1'b0;
    // Full scale inputs compare high at every trial
    logic full_scale;
    // Flip source for the reserved inputs
    always_ff @(posedge mclk)
    begin
        flip <= ~flip;
    end
    // Pins give their own level, references and sensors fixed levels
    assign full_scale = (|(route.pin_route & pin_level))
        | route.ref_high | route.temp_sensor
        | (route.bandgap & bandgap_buffer_enable)
        | (route.reserved & flip);
    // Nothing compares high while the converter is off
    assign comparator_high = route.powered & full_scale;
endmodule
`default_nettype wire

// File: testbench/acc_top_tb_top.sv
// Self-checking testbench for the converter channel and trigger control
`timescale 1ns/1ps
`default_nettype none
module acc_top_tb_top;
    localparam int LIM = 400;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic ctrl_write = 1'b0;
    acc_pkg::acc_ctrl_s ctrl_wdata = '0;
    acc_pkg::acc_cfg_s cfg = '0;
    logic [9:0] compare_value = 10'h000;
    logic [7:0] pin_en = 8'ha5;
    logic [7:0] pin_level = 8'h0f;
    logic result_low_read = 1'b0;
    logic stop3_mode = 1'b0;
    logic ref_out = 1'b0;
    logic use_ref = 1'b0;
    logic [2:0] rate = 3'h0;
    logic bg_en = 1'b0;
    logic lv_en = 1'b0;
    logic lv_stop_en = 1'b0;
    logic comp_high;
    acc_pkg::acc_route_s route;
    logic done, irq, active, trig;
    logic [9:0] result;
    int err_count = 0;
    int checks_done = 0;
    int n, n0, n1, n3, nl;
    logic [9:0] exp_res [4] = '{10'h3ff, 10'h000, 10'h3ff, 10'h000};
    logic [4:0] chans [4] = '{5'h1d, 5'h1e, 5'h00, 5'h01};

    acc_top #(.TICK_CYC(4)) dut (.mclk(mclk), .rst(rst), .ctrl_write(ctrl_write),
        .ctrl_wdata(ctrl_wdata), .cfg(cfg), .compare_value(compare_value),
        .pin_enable_register_1(pin_en), .result_low_read(result_low_read),
        .stop3_mode(stop3_mode), .clock_module_reference_out(ref_out),
        .periodic_use_reference(use_ref), .periodic_rate_select(rate),
        .comparator_high(comp_high), .route(route), .conversion_done_flag(done),
        .conversion_irq(irq), .conversion_active(active), .result(result),
        .hardware_conversion_trigger(trig));
    acc_analog_model far_side (.mclk(mclk), .pin_level(pin_level),
        .bandgap_buffer_enable(bg_en), .route(route), .comparator_high(comp_high));

    // Bus clock, 8 ns period
    always #4 mclk = ~mclk;
    // Reference clock rises every six bus cycles, kept off the bus edges
    initial
    begin
        #5;
        forever
        begin
            #24;
            ref_out = use_ref & ~ref_out;
        end
    end

    // Compare one value and count it
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            err_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Report counts and the verdict, then end
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // One control word write
    task automatic wr(input logic ie, input logic cont, input logic [4:0] ch);
        @(posedge mclk);
        #1 ctrl_write = 1'b1;
        ctrl_wdata = '{int_enable: ie, continuous: cont, input_channel_select: ch};
        @(posedge mclk);
        #1 ctrl_write = 1'b0;
    endtask
    // One cycle pulse reading the low result byte
    task automatic rd_low();
        @(posedge mclk);
        #1 result_low_read = 1'b1;
        @(posedge mclk);
        #1 result_low_read = 1'b0;
    endtask
    // Cycles until the done flag rises, LIM when it never does
    task automatic wait_done(output int cnt);
        cnt = 0;
        while (done !== 1'b1 && cnt < LIM)
        begin
            @(posedge mclk);
            #1 cnt++;
        end
    endtask
    // Cycles until the next trigger pulse
    task automatic wait_trig(output int cnt);
        cnt = 0;
        do
        begin
            @(posedge mclk);
            #1 cnt++;
        end while (trig !== 1'b1 && cnt < LIM);
    endtask
    // Start a single conversion and time it
    task automatic conv(input logic ie, input logic [4:0] ch, output int cnt);
        wr(ie, 1'b0, ch);
        wait_done(cnt);
    endtask
    // Routing expected for a channel code
    function automatic acc_pkg::acc_route_s exp_route(input logic [4:0] ch);
        acc_pkg::acc_route_s r;
        r = '0;
        r.powered = (ch != 5'h1f);
        r.pin_route = (ch < 5'h08) ? ((8'h01 << ch) & pin_en) : 8'h00;
        r.ground = (ch >= 5'h08 && ch <= 5'h15);
        r.reserved = (ch >= 5'h16 && ch <= 5'h19) || ch == 5'h1c;
        r.temp_sensor = (ch == 5'h1a);
        r.bandgap = (ch == 5'h1b);
        r.ref_high = (ch == 5'h1d);
        r.ref_low = (ch == 5'h1e);
        return r;
    endfunction

    // Watchdog well beyond the expected run
    initial
    begin
        #200000;
        err_count++;
        stop_test();
    end

    // Main test sequence
    initial
    begin
        repeat (10) @(posedge mclk);
        #1 rst = 1'b0;
        check({route, done, irq, active, trig}, 19'h00000);
        check(result, 10'h000);
        $display("test reset done");
        bg_en = 1'b1;
        for (int c = 0; c < 32; c++)
        begin
            wr(1'b0, 1'b0, c[4:0]);
            repeat (2) @(posedge mclk);
            #1 check(route, exp_route(c[4:0]));
        end
        check(active, 1'b0);
        $display("test decode done");
        for (int i = 0; i < 4; i++)
        begin
            conv(1'b1, chans[i], n);
            check({done, irq}, 2'b11);
            check(result, exp_res[i]);
            repeat (2) @(posedge mclk);
            #1 check(active, 1'b0);
        end
        rd_low();
        check({done, irq}, 2'b00);
        cfg.mode8 = 1'b1;
        conv(1'b0, 5'h1d, n);
        check(result, 10'h0ff);
        cfg.mode8 = 1'b0;
        cfg.low_power = 1'b1;
        conv(1'b0, 5'h1d, n);
        check({route.powered, active, result}, {2'b00, 10'h3ff});
        cfg.low_power = 1'b0;
        wr(1'b0, 1'b0, 5'h1f);
        check(done, 1'b0);
        $display("test single done");
        conv(1'b0, 5'h1d, n0);
        cfg.long_sample = 1'b1;
        conv(1'b0, 5'h1d, nl);
        check(16'(nl - n0), 16'd20);
        cfg.long_sample = 1'b0;
        cfg.clk_sel = 2'b01;
        conv(1'b0, 5'h1d, n1);
        cfg.clk_sel = 2'b11;
        conv(1'b0, 5'h1d, n3);
        check({n1 > n0, n3 > n1, n3 < LIM}, 3'b111);
        cfg.clk_sel = 2'b00;
        $display("test clocking done");
        wr(1'b0, 1'b0, 5'h1d);
        repeat (5) @(posedge mclk);
        conv(1'b0, 5'h1e, n);
        check(16'(n), 16'(n0));
        check(result, 10'h000);
        wr(1'b0, 1'b1, 5'h1d);
        wait_done(n);
        rd_low();
        check(done, 1'b0);
        wait_done(n);
        check(done, 1'b1);
        wr(1'b0, 1'b1, 5'h1f);
        wait_done(n);
        check({16'(n), active}, {16'(LIM), 1'b0});
        $display("test continuous done");
        cfg.cmp_enable = 1'b1;
        compare_value = 10'h100;
        conv(1'b0, 5'h1d, n);
        check(done, 1'b0);
        cfg.cmp_greater_equal = 1'b1;
        conv(1'b0, 5'h1d, n);
        check(done, 1'b1);
        cfg.cmp_greater_equal = 1'b0;
        conv(1'b0, 5'h1e, n);
        check(done, 1'b1);
        cfg.cmp_enable = 1'b0;
        $display("test compare done");
        lv_en = 1'b1;
        lv_stop_en = 1'b1;
        stop3_mode = lv_en & lv_stop_en;
        cfg.hw_trig_enable = 1'b1;
        wr(1'b0, 1'b0, 5'h1d);
        wait_trig(n);
        @(posedge mclk);
        #1 check(trig, 1'b0);
        wait_trig(n);
        check(16'(n), 16'd31);
        rd_low();
        wait_done(n);
        check(done, 1'b1);
        check(result, 10'h3ff);
        use_ref = 1'b1;
        rate = 3'h1;
        wait_trig(n);
        wait_trig(n);
        @(posedge mclk);
        #1 check(trig, 1'b0);
        wait_trig(n);
        check(16'(n), 16'd95);
        $display("test trigger done");
        stop_test();
    end
endmodule
`default_nettype wire
